// file: logic/dcm_pkg.sv
// constants and types for the ddr command and mode logic
// assumes one 50 MHz clock shared by every module that imports it
package dcm_pkg;
   // pin vector layout after synchronising
   localparam int ADDR_W      = 13;
   localparam int COL_W       = 11;
   localparam int PIN_W       = 21;
   // mode register fields
   localparam int BL_LSB      = 0;
   localparam int BT_BIT      = 3;
   localparam int CL_LSB      = 4;
   localparam int OPM_LSB     = 7;
   localparam int DLL_RST_BIT = 8;
   localparam int AP_BIT      = 10;
   // extended mode register fields
   localparam int EDLL_BIT    = 0;
   localparam int EDRV_BIT    = 1;
   localparam logic [12:0] MR_RST  = 13'h0000;
   localparam logic [12:0] EMR_RST = 13'h0000;
   // field codes
   localparam logic [2:0] BL_2   = 3'h1;
   localparam logic [2:0] BL_4   = 3'h2;
   localparam logic [2:0] BL_8   = 3'h3;
   localparam logic [2:0] CL_2   = 3'h2;
   localparam logic [2:0] CL_25  = 3'h6;
   localparam logic [5:0] OPM_NORMAL = 6'h00;
   localparam logic [5:0] OPM_DLLRST = 6'h02;
   localparam logic [1:0] SEL_BASE   = 2'h0;
   localparam logic [1:0] SEL_EXT    = 2'h1;
   // dll settle time in clock cycles with clock enable high
   localparam int DLL_SETTLE_CYC = 200;
   localparam logic [7:0] DLL_LAST = 8'(DLL_SETTLE_CYC - 1);
   // decoded commands, one-hot
   typedef enum logic [9:0] {
      CMD_NOP  = 10'h001,
      CMD_ACT  = 10'h002,
      CMD_RD   = 10'h004,
      CMD_WR   = 10'h008,
      CMD_BT   = 10'h010,
      CMD_PRE  = 10'h020,
      CMD_REF  = 10'h040,
      CMD_SREF = 10'h080,
      CMD_MRS  = 10'h100,
      CMD_RSV  = 10'h200
   } dcm_cmd_e;
endpackage

// file: logic/dcm_burst_if.sv
// link between the command decoder and the burst column walker
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface dcm_burst_if;
   import dcm_pkg::*;
   logic             start;
   logic             wr;
   logic             stop;
   logic [COL_W-1:0] start_col;
   logic [2:0]       bl_code;
   logic             interleave;
   logic             active;
   logic             is_wr;
   logic             last;
   logic [COL_W-1:0] col;
   modport ctrl (output start, wr, stop, start_col, bl_code, interleave,
                 input active, is_wr, last, col);
   modport walk (input start, wr, stop, start_col, bl_code, interleave,
                 output active, is_wr, last, col);
endinterface

// file: logic/dcm_burst.sv
// burst column walker: steps the low column bits inside an aligned block
// assumes start only arrives with a legal burst length code
`timescale 1ns/1ns
module dcm_burst
   import dcm_pkg::*;
(
   // clock and reset
   input wire logic   ref_clk_i,
   input wire logic   rst_n_i,
   // command side
   dcm_burst_if.walk  bif
);
   logic [COL_W-1:0] base_q, base_d;
   logic [2:0]       cnt_q, cnt_d;
   logic [2:0]       mask_q, mask_d;
   logic             ilv_q, ilv_d;
   logic             act_q, act_d;
   logic             wr_q, wr_d;
   logic [COL_W-1:0] col_q, col_d;
   logic [2:0]       lo;

   // next column and burst progress
   always_comb begin
      base_d = base_q;
      cnt_d  = cnt_q;
      mask_d = mask_q;
      ilv_d  = ilv_q;
      act_d  = act_q;
      wr_d   = wr_q;
      if (bif.start) begin
         base_d = bif.start_col;
         mask_d = (bif.bl_code == BL_8) ? 3'h7 : (bif.bl_code == BL_4) ? 3'h3 : 3'h1;
         ilv_d  = bif.interleave;
         cnt_d  = 3'h0;
         act_d  = 1'b1;
         wr_d   = bif.wr;
      end else if (act_q) begin
         cnt_d = cnt_q + 3'h1;
         if (cnt_q == mask_q || (bif.stop && !wr_q)) begin
            act_d = 1'b0;
         end
      end
      // sequential adds, interleaved xors, both wrap in the block
      lo = ilv_d ? ((base_d[2:0] ^ cnt_d) & mask_d)
                 : ((base_d[2:0] + cnt_d) & mask_d);
      col_d = {base_d[COL_W-1:3], (base_d[2:0] & ~mask_d) | lo};
   end

   // state registers
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         base_q <= '0;
         cnt_q  <= 3'h0;
         mask_q <= 3'h1;
         ilv_q  <= 1'b0;
         act_q  <= 1'b0;
         wr_q   <= 1'b0;
         col_q  <= '0;
      end else begin
         base_q <= base_d;
         cnt_q  <= cnt_d;
         mask_q <= mask_d;
         ilv_q  <= ilv_d;
         act_q  <= act_d;
         wr_q   <= wr_d;
         col_q  <= col_d;
      end
   end

   assign bif.active = act_q;
   assign bif.is_wr  = wr_q;
   assign bif.col    = col_q;
   assign bif.last   = act_q && (cnt_q == mask_q);

   // block bits above the start field never move during a burst
   chk_block_stays: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      act_q && !bif.start |=> !act_q || (col_q[COL_W-1:3] == $past(col_q[COL_W-1:3])))
      else $error("burst left its block");
endmodule

// file: logic/dcm_top.sv
// ddr command decode, mode registers, dll settle and burst control
// assumes command pins come from another clock domain and are synchronised
// Summary of operation
// - base load with only dll reset bit set starts a dll reset.
// - extended register holds drive strength until rewritten; dll disable also clears on self refresh exit.
// - leaving self refresh re-enables the dll without a load.
// - deselect and no-operation both do nothing.
// - row strobe alone low activates the selected bank and row.
// - column strobe low with row strobe high starts read or write; bit ten asks auto precharge.
// - burst terminate ends read bursts without auto precharge only.
// - precharge one bank, or all banks when bit ten is high.
// - refresh with clock enable high, self refresh entry when low.
// - all strobes low load base or extended register by bank code.
// - write mask low stores the element, high leaves memory unchanged.
// - sequential bursts add the count, interleaved bursts xor it.
// - bursts wrap inside an aligned block of burst length.
// - base register: length, type, latency, then op-mode bits.
// - dll reset bit clears itself, other mode bits persist.
// - first read data appears two cycles after the read; rd_half_o marks latency 2.5.
`timescale 1ns/1ns
module dcm_top
   import dcm_pkg::*;
(
   // clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   // command pins
   input  wire logic              chip_sel_n_i,
   input  wire logic              row_strobe_n_i,
   input  wire logic              col_strobe_n_i,
   input  wire logic              write_en_n_i,
   input  wire logic              clk_en_i,
   input  wire logic              bank_select_lo_i,
   input  wire logic              bank_select_hi_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic              write_mask_i,
   // decoded command
   output logic [9:0]             cmd_o,
   output logic [1:0]             bank_o,
   output logic [ADDR_W-1:0]      row_o,
   output logic [3:0]             pre_banks_o,
   output logic                   auto_precharge_o,
   // burst
   output logic                   burst_active_o,
   output logic                   burst_write_o,
   output logic [COL_W-1:0]       burst_col_o,
   output logic                   mem_write_en_o,
   output logic                   rd_valid_o,
   output logic                   rd_half_o,
   // mode state
   output logic [12:0]            mode_reg_o,
   output logic [12:0]            ext_mode_reg_o,
   output logic                   dll_reset_o,
   output logic                   dll_ready_o,
   output logic                   self_refresh_o,
   output logic                   mode_reserved_o
);
   dcm_burst_if bif ();

   // decode the strobe pattern into a one-hot command
   function automatic dcm_cmd_e decode(input logic [3:0] p);
      dcm_cmd_e c;
      c = CMD_NOP;
      if (!p[3]) begin
         // row, column and write strobes, every code listed
         unique case (p[2:0])
            3'b111: c = CMD_NOP;
            3'b011: c = CMD_ACT;
            3'b101: c = CMD_RD;
            3'b100: c = CMD_WR;
            3'b110: c = CMD_BT;
            3'b010: c = CMD_PRE;
            3'b001: c = CMD_REF;
            3'b000: c = CMD_MRS;
         endcase
      end
      return c;
   endfunction

   // two-stage pin synchroniser
   logic [PIN_W-1:0] pin_m_q, pin_q;
   always_ff @(posedge ref_clk_i) begin
      pin_m_q <= {chip_sel_n_i, row_strobe_n_i, col_strobe_n_i, write_en_n_i, clk_en_i,
                  bank_select_hi_i, bank_select_lo_i, addr_i, write_mask_i};
      pin_q   <= pin_m_q;
   end

   logic              cs_n, ras_n, cas_n, we_n, cke, wm;
   logic [1:0]        ba;
   logic [ADDR_W-1:0] a;
   dcm_cmd_e          cmd;
   assign {cs_n, ras_n, cas_n, we_n, cke, ba, a, wm} = pin_q;

   // refresh versus self refresh rides on clock enable
   always_comb begin
      cmd = decode({cs_n, ras_n, cas_n, we_n});
      if (cmd == CMD_REF && !cke) begin
         cmd = CMD_SREF;
      end
   end

   // registered state
   logic [9:0]        cmd_q, cmd_d;
   logic [1:0]        bank_q, bank_d;
   logic [ADDR_W-1:0] row_q, row_d;
   logic [3:0]        pre_q, pre_d;
   logic              ap_q, ap_d;
   logic [12:0]       mr_q, mr_d, emr_q, emr_d;
   logic              dllrst_q, dllrst_d;
   logic [7:0]        dcnt_q, dcnt_d;
   logic              rdy_q, rdy_d;
   logic              sref_q, sref_d;
   logic              rsv_q, rsv_d;
   logic              wen_q, wen_d;
   logic [1:0]        rdp_q, rdp_d;
   logic              half_q, half_d;
   logic              ap_burst_q, ap_burst_d;
   logic              restart;

   // command effects on mode and bank outputs
   always_comb begin
      cmd_d      = cmd;
      bank_d     = bank_q;
      row_d      = row_q;
      pre_d      = 4'h0;
      ap_d       = 1'b0;
      mr_d       = mr_q;
      emr_d      = emr_q;
      dllrst_d   = 1'b0;
      sref_d     = sref_q;
      ap_burst_d = ap_burst_q;
      restart    = 1'b0;
      if (sref_q) begin
         cmd_d = CMD_NOP;
         if (cke) begin
            sref_d        = 1'b0;
            emr_d[EDLL_BIT] = 1'b0;
            restart       = 1'b1;
         end
      end else begin
         unique case (cmd)
            CMD_ACT: begin
               bank_d = ba;
               row_d  = a;
            end
            CMD_RD, CMD_WR: begin
               bank_d     = ba;
               ap_d       = a[AP_BIT];
               ap_burst_d = a[AP_BIT];
            end
            CMD_PRE: pre_d = a[AP_BIT] ? 4'hf : 4'(1 << ba);
            CMD_SREF: sref_d = 1'b1;
            CMD_MRS: begin
               if (ba == SEL_BASE) begin
                  mr_d = a & ~(13'h0001 << DLL_RST_BIT);
                  if (a[12:OPM_LSB] == OPM_DLLRST) begin
                     dllrst_d = 1'b1;
                     restart  = 1'b1;
                  end
               end else if (ba == SEL_EXT) begin
                  emr_d = a;
                  if (emr_q[EDLL_BIT] && !a[EDLL_BIT]) begin
                     restart = 1'b1;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // dll settle count, latency and write mask
   always_comb begin
      dcnt_d = dcnt_q;
      rdy_d  = rdy_q;
      if (restart || emr_q[EDLL_BIT]) begin
         dcnt_d = 8'h00;
         rdy_d  = 1'b0;
      end else if (!rdy_q && cke) begin
         dcnt_d = dcnt_q + 8'h01;
         rdy_d  = (dcnt_q == DLL_LAST);
      end
      // flags follow the mode register on the same edge
      rsv_d  = (mr_d[12:OPM_LSB] != OPM_NORMAL)
             || !(mr_d[6:CL_LSB] inside {CL_2, CL_25})
             || !(mr_d[2:BL_LSB] inside {BL_2, BL_4, BL_8});
      wen_d  = bif.active && bif.is_wr && !wm;
      rdp_d  = {rdp_q[0], bif.active && !bif.is_wr};
      half_d = (mr_d[6:CL_LSB] == CL_25);
   end

   // burst walker hookup
   assign bif.start      = !sref_q && (cmd == CMD_RD || cmd == CMD_WR);
   assign bif.wr         = (cmd == CMD_WR);
   assign bif.stop       = (cmd == CMD_BT) && !ap_burst_q && !sref_q;
   assign bif.start_col  = {a[11], a[9:0]};
   assign bif.bl_code    = mr_q[2:BL_LSB];
   assign bif.interleave = mr_q[BT_BIT];

   dcm_burst u_burst (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .bif       (bif)
   );

   // state registers
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         cmd_q      <= CMD_NOP;
         bank_q     <= 2'h0;
         row_q      <= '0;
         pre_q      <= 4'h0;
         ap_q       <= 1'b0;
         mr_q       <= MR_RST;
         emr_q      <= EMR_RST;
         dllrst_q   <= 1'b0;
         dcnt_q     <= 8'h00;
         rdy_q      <= 1'b0;
         sref_q     <= 1'b0;
         rsv_q      <= 1'b1; // reset mode value is a reserved code
         wen_q      <= 1'b0;
         rdp_q      <= 2'h0;
         half_q     <= 1'b0;
         ap_burst_q <= 1'b0;
      end else begin
         cmd_q      <= cmd_d;
         bank_q     <= bank_d;
         row_q      <= row_d;
         pre_q      <= pre_d;
         ap_q       <= ap_d;
         mr_q       <= mr_d;
         emr_q      <= emr_d;
         dllrst_q   <= dllrst_d;
         dcnt_q     <= dcnt_d;
         rdy_q      <= rdy_d;
         sref_q     <= sref_d;
         rsv_q      <= rsv_d;
         wen_q      <= wen_d;
         rdp_q      <= rdp_d;
         half_q     <= half_d;
         ap_burst_q <= ap_burst_d;
      end
   end

   // outputs straight from flops
   assign cmd_o            = cmd_q;
   assign bank_o           = bank_q;
   assign row_o            = row_q;
   assign pre_banks_o      = pre_q;
   assign auto_precharge_o = ap_q;
   assign burst_active_o   = bif.active;
   assign burst_write_o    = bif.is_wr;
   assign burst_col_o      = bif.col;
   assign mem_write_en_o   = wen_q;
   assign rd_valid_o       = rdp_q[1];
   assign rd_half_o        = half_q;
   assign mode_reg_o       = mr_q;
   assign ext_mode_reg_o   = emr_q;
   assign dll_reset_o      = dllrst_q;
   assign dll_ready_o      = rdy_q;
   assign self_refresh_o   = sref_q;
   assign mode_reserved_o  = rsv_q;

   chk_dll_bit_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !mr_q[DLL_RST_BIT]) else $error("dll reset bit stuck in mode reg");
   chk_dll_rst_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      dllrst_q |=> !dllrst_q [*1] ##0 !rdy_q) else $error("dll reset not a pulse");
   chk_dll_settle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(rdy_q) |-> $past(dcnt_q) == DLL_LAST) else $error("dll ready early");
   chk_pre_all: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      cmd_q == CMD_PRE && $past(a[AP_BIT]) |-> pre_q == 4'hf)
      else $error("precharge all missed");
   chk_write_mask: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      wen_q |-> $past(wm) == 1'b0 && $past(bif.is_wr)) else $error("masked write stored");
   chk_rd_latency: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      cmd_q == CMD_RD |-> ##2 rd_valid_o) else $error("read data not on time");
   chk_sref_exit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      sref_q && cke |=> !sref_q && !emr_q[EDLL_BIT] && !rdy_q)
      else $error("self refresh exit kept dll off");
   chk_emr_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !(cmd_q == CMD_MRS && $past(ba) == SEL_EXT) && !$past(sref_q) |-> $stable(emr_q))
      else $error("extended register changed alone");
   chk_bt_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      bif.stop && bif.active && !bif.is_wr && !bif.start |=> !bif.active)
      else $error("burst terminate ignored");
   chk_burst_end: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      bif.last && !bif.start |=> !bif.active) else $error("burst overran its length");
endmodule

// file: testbench/dcm_host_model.sv
// host controller model that drives the ddr command pins
// assumes callers invoke its tasks just after a rising clock edge
`timescale 1ns/1ns
module dcm_host_model
   import dcm_pkg::*;
(
   // clock
   input  wire logic              ref_clk_i,
   // command pins
   output logic                   chip_sel_n_o,
   output logic [2:0]             strobe_n_o,
   output logic                   clk_en_o,
   output logic [1:0]             bank_o,
   output logic [ADDR_W-1:0]      addr_o,
   output logic                   write_mask_o
);
   // idle: deselected with clock enable high
   initial begin
      chip_sel_n_o = 1'b1;
      strobe_n_o   = 3'h7;
      clk_en_o     = 1'b1;
      bank_o       = 2'h0;
      addr_o       = 13'h0000;
      write_mask_o = 1'b1;
   end
   // one command for one edge, then deselect and scramble the address
   task automatic issue(input logic [3:0] code, input logic cke, input logic [1:0] ba,
                        input logic [ADDR_W-1:0] a);
      {chip_sel_n_o, strobe_n_o} = code;
      clk_en_o = cke;
      bank_o   = ba;
      addr_o   = a;
      @(posedge ref_clk_i);
      #1;
      chip_sel_n_o = 1'b1;
      strobe_n_o   = 3'h7;
      bank_o       = ~ba;
      addr_o       = ~a;
   endtask
   // mask held for a whole write burst
   task automatic set_mask(input logic m);
      write_mask_o = m;
   endtask
endmodule

// file: testbench/dcm_top_bench.sv
// self-checking bench for the ddr command and mode logic
// assumes outputs follow the pin sampling edge by two more edges
`timescale 1ns/1ns
module dcm_top_bench;
   import dcm_pkg::*;
   localparam logic [3:0] TBL_CODE [6] = '{4'h8, 4'h7, 4'h3, 4'h6, 4'h2, 4'h1};
   localparam logic [9:0] TBL_CMD  [6] = '{CMD_NOP, CMD_NOP, CMD_ACT, CMD_BT, CMD_PRE, CMD_REF};
   logic              ref_clk_i = 1'b0;
   logic              rst_n_i   = 1'b0;
   logic              cs_n;
   logic [2:0]        st_n;
   logic              cke;
   logic [1:0]        ba_p;
   logic [ADDR_W-1:0] a_p;
   logic              wm;
   logic [9:0]        cmd_o;
   logic [1:0]        bank_o;
   logic [ADDR_W-1:0] row_o;
   logic [3:0]        pre_banks_o;
   logic              auto_precharge_o, burst_active_o, burst_write_o, mem_write_en_o;
   logic [COL_W-1:0]  burst_col_o;
   logic              rd_valid_o, rd_half_o, dll_reset_o, dll_ready_o;
   logic [12:0]       mode_reg_o, ext_mode_reg_o;
   logic              self_refresh_o, mode_reserved_o;
   int                errors, checked, bc, il, wr, i, k, n, bl;
   logic [1:0]        ba;
   logic [ADDR_W-1:0] a, m;
   logic [COL_W-1:0]  sc;
   logic              mask;
   // 50 MHz clock
   always #10 ref_clk_i = ~ref_clk_i;
   dcm_host_model host (.ref_clk_i(ref_clk_i), .chip_sel_n_o(cs_n), .strobe_n_o(st_n),
      .clk_en_o(cke), .bank_o(ba_p), .addr_o(a_p), .write_mask_o(wm));
   dcm_top dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .chip_sel_n_i(cs_n),
      .row_strobe_n_i(st_n[2]), .col_strobe_n_i(st_n[1]), .write_en_n_i(st_n[0]),
      .clk_en_i(cke), .bank_select_lo_i(ba_p[0]), .bank_select_hi_i(ba_p[1]),
      .addr_i(a_p), .write_mask_i(wm), .cmd_o(cmd_o), .bank_o(bank_o), .row_o(row_o),
      .pre_banks_o(pre_banks_o), .auto_precharge_o(auto_precharge_o),
      .burst_active_o(burst_active_o), .burst_write_o(burst_write_o),
      .burst_col_o(burst_col_o), .mem_write_en_o(mem_write_en_o), .rd_valid_o(rd_valid_o),
      .rd_half_o(rd_half_o), .mode_reg_o(mode_reg_o), .ext_mode_reg_o(ext_mode_reg_o),
      .dll_reset_o(dll_reset_o), .dll_ready_o(dll_ready_o), .self_refresh_o(self_refresh_o),
      .mode_reserved_o(mode_reserved_o));
   // verdict and end of run
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // single comparison point
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // land just after the edge where the answer shows
   task automatic wait_ans();
      repeat (2) @(posedge ref_clk_i);
      #1;
   endtask
   // bounded wait for dll settle, returns cycle count in n
   task automatic wait_ready();
      for (n = 0; n < 400 && dll_ready_o !== 1'b1; n++) begin
         @(posedge ref_clk_i);
         #1;
      end
      if (n >= 400) begin
         errors++;
         finish_test();
      end
   endtask
   // model: reserved field codes of the base register
   function automatic logic rsv(input logic [12:0] r);
      return !(r[12:7] inside {OPM_NORMAL, OPM_DLLRST}) || !(r[6:4] inside {CL_2, CL_25})
             || !(r[2:0] inside {BL_2, BL_4, BL_8});
   endfunction
   // model: column of element i in an aligned block
   function automatic logic [COL_W-1:0] exp_col(input logic [COL_W-1:0] s, input int len,
                                               input int ilv, input int idx);
      int lo;
      lo = ilv ? ((s % len) ^ idx) : (((s % len) + idx) % len);
      return (s & ~COL_W'(len - 1)) | COL_W'(lo);
   endfunction
   // watchdog
   initial begin
      repeat (100000) @(posedge ref_clk_i);
      errors++;
      finish_test();
   end
   // main sequence
   initial begin
      errors = 0;
      checked = 0;
      void'($urandom(19));
      repeat (10) @(posedge ref_clk_i);
      #1 rst_n_i = 1'b1;
      check(cmd_o, CMD_NOP);
      check(mode_reserved_o, rsv(13'h0000));
      // decode table with random bank and address
      for (k = 0; k < 6; k++) begin
         ba = 2'($urandom);
         a  = 13'($urandom);
         host.issue(TBL_CODE[k], 1'b1, ba, a);
         wait_ans();
         check(cmd_o, TBL_CMD[k]);
         if (k == 2) check({bank_o, row_o}, {ba, a});
         if (k == 4) check(pre_banks_o, a[AP_BIT] ? 4'hf : 4'(1 << ba));
      end
      // every burst length, type and direction
      for (bc = 1; bc <= 3; bc++) for (il = 0; il < 2; il++) for (wr = 0; wr < 2; wr++) begin
         m = {6'h00, il ? CL_25 : CL_2, il[0], 3'(bc)};
         host.issue(4'h0, 1'b1, 2'h0, m);
         wait_ans();
         check(mode_reg_o, m);
         check(rd_half_o, il[0]);
         check(mode_reserved_o, rsv(m));
         bl   = 1 << bc;
         sc   = 11'($urandom);
         mask = 1'($urandom);
         host.set_mask(mask);
         host.issue(wr ? 4'h4 : 4'h5, 1'b1, 2'($urandom), {1'b0, sc[10], 1'b0, sc[9:0]});
         wait_ans();
         check(cmd_o, wr ? CMD_WR : CMD_RD);
         for (i = 0; i <= bl + 1; i++) begin
            check(burst_active_o, i < bl);
            if (i < bl) check({burst_write_o, burst_col_o}, {wr[0], exp_col(sc, bl, il, i)});
            check(mem_write_en_o, wr && !mask && i >= 1 && i <= bl);
            check(rd_valid_o, !wr && i >= 2 && i <= bl + 1);
            @(posedge ref_clk_i);
            #1;
         end
      end
      // read then terminate: ignored with auto precharge, obeyed without
      for (k = 0; k < 2; k++) begin
         host.issue(4'h5, 1'b1, 2'h1, k ? 13'h0000 : 13'h0400);
         @(posedge ref_clk_i);
         #1;
         host.issue(4'h6, 1'b1, 2'h0, 13'h0000);
         check({cmd_o, auto_precharge_o}, {CMD_RD, !k[0]});
         repeat (2) @(posedge ref_clk_i);
         #1;
         check({cmd_o, burst_active_o}, {CMD_BT, !k[0]});
         repeat (6) @(posedge ref_clk_i);
         #1;
         check(burst_active_o, 1'b0);
      end
      // dll reset load, settle time, then a normal load and a reserved op-mode load
      host.issue(4'h0, 1'b1, 2'h0, 13'h0122);
      wait_ans();
      check({mode_reg_o, dll_reset_o, dll_ready_o}, {13'h0022, 1'b1, 1'b0});
      @(posedge ref_clk_i);
      #1;
      check(dll_reset_o, 1'b0);
      wait_ready();
      check(n >= 198 && n <= 200, 1'b1);
      host.issue(4'h0, 1'b1, 2'h0, 13'h0022);
      wait_ans();
      check(mode_reserved_o, 1'b0);
      host.issue(4'h0, 1'b1, 2'h0, 13'h0422);
      wait_ans();
      check({mode_reg_o, mode_reserved_o}, {13'h0422, rsv(13'h0422)});
      // extended load, then a reserved bank code that must be ignored
      host.issue(4'h0, 1'b1, 2'h1, 13'h0003);
      @(posedge ref_clk_i);
      #1;
      host.issue(4'h0, 1'b1, 2'h2, 13'h0070);
      check({ext_mode_reg_o, mode_reg_o}, {13'h0003, 13'h0422});
      repeat (2) @(posedge ref_clk_i);
      #1;
      check({ext_mode_reg_o, mode_reg_o}, {13'h0003, 13'h0422});
      repeat (5) @(posedge ref_clk_i);
      #1;
      check(dll_ready_o, 1'b0);
      // self refresh entry, ignored command, exit re-enables the dll
      host.issue(4'h1, 1'b0, 2'h0, 13'h0000);
      wait_ans();
      check({cmd_o, self_refresh_o}, {CMD_SREF, 1'b1});
      host.issue(4'h3, 1'b0, 2'h3, 13'h1fff);
      wait_ans();
      check(cmd_o, CMD_NOP);
      host.issue(4'h8, 1'b1, 2'h0, 13'h0000);
      wait_ans();
      wait_ready();
      check({self_refresh_o, ext_mode_reg_o}, {1'b0, 13'h0002});
      check(n >= 196 && n <= 201, 1'b1);
      finish_test();
   end
endmodule
